// ---- verilog/uvee_pkg.sv ----
// package: offsets, field positions, reset values and carriers for the vendor bytes
package uvee_pkg;
   // register offsets on the bus (byte addresses, index times four)
   localparam logic [7:0] UVEE_CFG_SET_IDX = 8'h89;
   localparam logic [7:0] UVEE_CFG_CLR_IDX = 8'h8a;
   localparam logic [7:0] UVEE_EVT_EN_IDX = 8'h8b;
   localparam logic [7:0] UVEE_STATUS_IDX = 8'hc0;
   localparam logic [9:0] UVEE_CFG_SET_ADR = {UVEE_CFG_SET_IDX, 2'b00};
   localparam logic [9:0] UVEE_CFG_CLR_ADR = {UVEE_CFG_CLR_IDX, 2'b00};
   localparam logic [9:0] UVEE_EVT_EN_ADR = {UVEE_EVT_EN_IDX, 2'b00};
   localparam logic [9:0] UVEE_STATUS_ADR = {UVEE_STATUS_IDX, 2'b00};
   // configuration byte fields
   localparam int CFG_ACA_DET = 6;
   localparam int CFG_RVBUS = 5;
   localparam int CFG_SERIES = 4;
   localparam int CFG_POL = 3;
   localparam int CFG_PUSHPULL = 2;
   localparam int CFG_CMP_DP = 1;
   localparam int CFG_CMP_DM = 0;
   localparam logic [7:0] UVEE_CFG_RST = 8'h70;
   localparam logic [7:0] UVEE_CFG_WMASK = 8'h7c;
   // event enable byte fields
   localparam int EV_RESUME_WD = 6;
   localparam int EV_ID_OPEN = 5;
   localparam int EV_ACC_RES = 4;
   localparam int EV_SESS_WD = 3;
   localparam int EV_VBUS_RISE = 2;
   localparam int EV_VBUS_FALL = 1;
   localparam int EV_SUPPLY = 0;
   localparam logic [7:0] UVEE_EVT_RST = 8'h40;
   localparam logic [7:0] UVEE_EVT_WMASK = 8'h7f;
   // status register fields (accessory status in bits 1:0)
   localparam int ST_ACC_LO = 0;
   localparam int ST_RESUME_RUN = 2;
   // analog sense inputs grouped together
   typedef struct packed {
      logic cmp_dplus;
      logic cmp_dminus;
      logic vbus_mon;
      logic supply_mon;
      logic id_open;
      logic [1:0] acc_res;
      logic sess_wd_timeout;
      logic resume_k;
   } uvee_sense_t;
   // event notifications, one-cycle pulses
   typedef struct packed {
      logic id_open;
      logic acc_res;
      logic sess_wd;
      logic vbus_rise;
      logic vbus_fall;
      logic supply;
   } uvee_event_t;
endpackage

// ---- verilog/uvee_regs.sv ----
// vendor charger/power-switch configuration and event-enable register bank
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ns
// Overview of operation
// - resume watchdog enable lets a resume-K start the watchdog timer; clear disables it
// - id open enable sends receive command on each id open indication change
// - accessory resistor enable sends alt-interrupt command on accessory state change
// - accessory resistor enable latches each detected resistor change into a two-bit status field
// - accessory resistor enable forces id pull-up on regardless of control bit
// - session wake watchdog enable raises event on that watchdog timeout
// - vbus monitor rise enable raises event on low-to-high monitor edge
// - vbus monitor fall enable raises event on high-to-low monitor edge
// - supply monitor enable reports each synchronised comparator transition
// - configuration byte has set view 0x89, clear view 0x8a; comparators read-only
// - event enable byte at 0x8b resets to only resume watchdog enable set
// - push-pull bit overrides polarity select on the power switch pin
// - series resistor bit shifts the vbus comparator thresholds
module uvee_regs #(
   parameter int RESUME_WD_CYCLES = 1000
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire uvee_pkg::uvee_sense_t sense_i,
   input wire logic id_pull_up_control_i,
   input wire logic power_switch_on_i,
   output uvee_pkg::uvee_event_t event_o,
   output logic alt_int_o,
   output logic id_pull_up_o,
   output logic psw_out_o,
   output logic psw_oe_o,
   output logic vbus_series_resistor_present_o,
   output logic a_device_vbus_resistor_enable_o,
   output logic accessory_detect_enable_o,
   output logic resume_watchdog_timeout_o
);
   import uvee_pkg::*;

   // refuse a watchdog length the 16-bit counter cannot hold
   if (RESUME_WD_CYCLES < 1 || RESUME_WD_CYCLES > 65535) begin : g_bad_len
      $error("RESUME_WD_CYCLES out of range");
   end

   logic [7:0] cfg_q, cfg_d, evt_q, evt_d;
   logic [1:0] acc_q;
   logic [31:0] dat_q;
   logic ack_q;
   logic [15:0] wd_cnt_q;
   logic wd_run_q, wd_to_q;
   uvee_sense_t s1_q, s2_q, s3_q;
   uvee_event_t ev_q;
   logic alt_q, pu_q, psw_q, psw_oe_q;

   // one word-index compare shared by every register decode
   function automatic logic hit(input logic [9:0] adr, input logic [9:0] tgt);
      return adr == tgt;
   endfunction

   // bus decode; a write lands on the edge where the master sees ack,
   // so a master that drops the cycle early never half-writes a byte
   wire req = wb_cyc_i && wb_stb_i && !ack_q;
   wire wr0 = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
   wire [9:0] adr = wb_adr_i[11:2];
   wire [7:0] wdat = wb_dat_i[7:0];
   wire hit_set = hit(adr, {2'b00, UVEE_CFG_SET_IDX});
   wire hit_clr = hit(adr, {2'b00, UVEE_CFG_CLR_IDX});
   wire hit_evt = hit(adr, {2'b00, UVEE_EVT_EN_IDX});
   wire hit_sts = hit(adr, {2'b00, UVEE_STATUS_IDX});

   // live comparators fill the read-only bits of both views
   wire [7:0] cfg_view = {cfg_q[7:2], s2_q.cmp_dplus, s2_q.cmp_dminus};
   wire [7:0] sts_view = {5'h00, wd_run_q, acc_q};
   wire [7:0] rd_byte = (hit_set || hit_clr) ? cfg_view :
                        hit_evt ? evt_q :
                        hit_sts ? sts_view : 8'h00;

   // set view ors in ones, clear view masks them off; reserved stays zero
   assign cfg_d = (wr0 && hit_set) ? cfg_q | (wdat & UVEE_CFG_WMASK) :
                  (wr0 && hit_clr) ? cfg_q & ~(wdat & UVEE_CFG_WMASK) :
                  cfg_q;
   assign evt_d = (wr0 && hit_evt) ? wdat & UVEE_EVT_WMASK : evt_q;

   // registers and single-cycle ack; ack drops the cycle after it rose
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_q <= UVEE_CFG_RST;
         evt_q <= UVEE_EVT_RST;
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         cfg_q <= cfg_d;
         evt_q <= evt_d;
         ack_q <= req;
         dat_q <= req ? {24'h00_0000, rd_byte} : dat_q;
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // two-flop synchroniser plus one stage for edge detection
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= sense_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // edge events; disabled sources never notify
   wire id_chg = s2_q.id_open ^ s3_q.id_open;
   wire acc_chg = s2_q.acc_res != s3_q.acc_res;
   uvee_event_t ev_d;
   assign ev_d.id_open = evt_q[EV_ID_OPEN] && id_chg;
   assign ev_d.acc_res = evt_q[EV_ACC_RES] && acc_chg;
   assign ev_d.sess_wd = evt_q[EV_SESS_WD] && s2_q.sess_wd_timeout &&
                         !s3_q.sess_wd_timeout;
   assign ev_d.vbus_rise = evt_q[EV_VBUS_RISE] && s2_q.vbus_mon &&
                           !s3_q.vbus_mon;
   assign ev_d.vbus_fall = evt_q[EV_VBUS_FALL] && !s2_q.vbus_mon &&
                           s3_q.vbus_mon;
   assign ev_d.supply = evt_q[EV_SUPPLY] &&
                        (s2_q.supply_mon ^ s3_q.supply_mon);

   // power switch: push-pull drives always, else polarity picks high/low drive
   wire pp = cfg_q[CFG_PUSHPULL];
   wire od = cfg_q[CFG_POL];
   wire psw_lvl = (pp || !od) ? power_switch_on_i : 1'b0;
   wire psw_en = pp || power_switch_on_i;

   // event and pin outputs registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ev_q <= '0;
         alt_q <= 1'b0;
         acc_q <= 2'b00;
         pu_q <= 1'b0;
         psw_q <= 1'b0;
         psw_oe_q <= 1'b0;
      end else begin
         ev_q <= ev_d;
         alt_q <= ev_d.acc_res;
         acc_q <= ev_d.acc_res ? s2_q.acc_res : acc_q;
         pu_q <= id_pull_up_control_i || evt_q[EV_ACC_RES];
         psw_q <= psw_lvl;
         psw_oe_q <= psw_en;
      end
   end
   assign event_o = ev_q;
   assign alt_int_o = alt_q;
   assign id_pull_up_o = pu_q;
   assign psw_out_o = psw_q;
   assign psw_oe_o = psw_oe_q;
   assign vbus_series_resistor_present_o = cfg_q[CFG_SERIES];
   assign a_device_vbus_resistor_enable_o = cfg_q[CFG_RVBUS];
   assign accessory_detect_enable_o = cfg_q[CFG_ACA_DET];

   // resume watchdog: a resume-K loads and starts it, disable holds it idle
   wire rk_edge = s2_q.resume_k && !s3_q.resume_k;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wd_cnt_q <= 16'h0000;
         wd_run_q <= 1'b0;
         wd_to_q <= 1'b0;
      end else if (!evt_q[EV_RESUME_WD]) begin
         wd_cnt_q <= 16'h0000;
         wd_run_q <= 1'b0;
         wd_to_q <= 1'b0;
      end else if (rk_edge) begin
         wd_cnt_q <= 16'(RESUME_WD_CYCLES);
         wd_run_q <= 1'b1;
         wd_to_q <= 1'b0;
      end else if (wd_run_q) begin
         wd_cnt_q <= wd_cnt_q - 16'h0001;
         wd_run_q <= wd_cnt_q != 16'h0001;
         wd_to_q <= wd_cnt_q == 16'h0001;
      end else begin
         wd_to_q <= 1'b0;
      end
   end
   assign resume_watchdog_timeout_o = wd_to_q;

   // reset leaves only the watchdog enable set in the enable byte
   evt_reset_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      $past(rst_i) |-> evt_q == 8'h40)
      else $error("event enable reset value wrong");
   // reset sets the detect, idle resistor and series resistor bits
   cfg_reset_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      $past(rst_i) |-> cfg_q[7:2] == 6'h1c)
      else $error("config reset value wrong");
   // reserved top bits are masked on every write path
   resv_zero_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      !evt_q[7] && !cfg_q[7])
      else $error("reserved bit set");
   // an id open notification needs an enabled change one cycle earlier
   id_event_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      event_o.id_open |-> $past(evt_q[EV_ID_OPEN] && id_chg))
      else $error("id open event without cause");
   // and an enabled change is never dropped
   id_seen_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      evt_q[EV_ID_OPEN] && id_chg |=> event_o.id_open)
      else $error("id open change not reported");
   // the alternate interrupt travels with the accessory notification
   alt_int_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      alt_int_o == event_o.acc_res)
      else $error("alt int mismatch");
   // the alternate interrupt needs an enabled accessory change
   acc_cause_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      alt_int_o |-> $past(evt_q[EV_ACC_RES] && acc_chg))
      else $error("alt int without cause");
   // status captures the resistor code seen with the notification
   acc_status_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      event_o.acc_res |-> acc_q == $past(s2_q.acc_res))
      else $error("accessory status not captured");
   // accessory enable forces the pull-up whatever the control says
   pullup_force_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      $past(evt_q[EV_ACC_RES]) |-> id_pull_up_o)
      else $error("pull-up not forced");
   // session watchdog notifications only while enabled
   sess_event_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      event_o.sess_wd |-> $past(evt_q[EV_SESS_WD]))
      else $error("session event while disabled");
   // rising monitor notifications only while enabled
   rise_event_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      event_o.vbus_rise |-> $past(evt_q[EV_VBUS_RISE]))
      else $error("rise event while disabled");
   // an enabled rising edge is always reported
   rise_seen_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      evt_q[EV_VBUS_RISE] && $rose(s2_q.vbus_mon) |=> event_o.vbus_rise)
      else $error("rise edge not reported");
   // falling monitor notifications only while enabled
   fall_event_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      event_o.vbus_fall |-> $past(evt_q[EV_VBUS_FALL]))
      else $error("fall event while disabled");
   // an enabled falling edge is always reported
   fall_seen_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      evt_q[EV_VBUS_FALL] && $fell(s2_q.vbus_mon) |=> event_o.vbus_fall)
      else $error("fall edge not reported");
   // supply notifications only while monitoring is on
   supply_event_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      event_o.supply |-> $past(evt_q[EV_SUPPLY]))
      else $error("supply event while disabled");
   // both supply directions are reported while monitoring is on
   supply_seen_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      evt_q[EV_SUPPLY] && $changed(s2_q.supply_mon) |=> event_o.supply)
      else $error("supply change not reported");
   // a cleared enable holds the resume watchdog idle
   wd_off_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      !evt_q[EV_RESUME_WD] |=> !wd_run_q)
      else $error("watchdog ran");
   // a timeout only ends an enabled, running watchdog
   wd_timeout_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      resume_watchdog_timeout_o |-> $past(wd_run_q && evt_q[EV_RESUME_WD]))
      else $error("timeout without running watchdog");
   // push-pull drives the pin at all times
   psw_pp_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      cfg_q[CFG_PUSHPULL] |=> psw_oe_o)
      else $error("push-pull pin not driven");
   // open drain only ever pulls the pin low
   psw_od_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      !cfg_q[CFG_PUSHPULL] && cfg_q[CFG_POL] |=> !psw_out_o)
      else $error("open drain pin driven high");
   // a one written to the clear view clears the bit
   clr_view_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      wr0 && hit_clr && wdat[CFG_PUSHPULL] |=> !cfg_q[CFG_PUSHPULL])
      else $error("clear view failed");
   // a one written to the set view sets the bit
   set_view_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      wr0 && hit_set && wdat[CFG_SERIES] |=> cfg_q[CFG_SERIES])
      else $error("set view failed");
   // ack is a single-cycle pulse
   ack_pulse_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
   // ack only answers a request taken on the edge before
   ack_cause_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");

   // main scenarios: timeout, accessory and id events, set write, open drain
   wd_cov_c: cover property (@(posedge clk_i) resume_watchdog_timeout_o);
   acc_cov_c: cover property (@(posedge clk_i) event_o.acc_res);
   id_cov_c: cover property (@(posedge clk_i) event_o.id_open);
   set_cov_c: cover property (@(posedge clk_i) wr0 && hit_set);
   psw_cov_c: cover property (@(posedge clk_i) cfg_q[CFG_POL] && psw_oe_o);
endmodule

// ---- dv/uvee_link_model.sv ----
// link-side model: counts the notifications sent by the register bank
`timescale 1ns/1ns
module uvee_link_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire uvee_pkg::uvee_event_t event_i,
   input wire logic alt_int_i,
   input wire logic timeout_i
);
   import uvee_pkg::*;
   logic [7:0] cnt [8];
   wire logic [7:0] hit = {timeout_i, alt_int_i, event_i};
   // each pulse stands one cycle, so the link must take it on that edge
   always_ff @(posedge clk_i) begin
      for (int k = 0; k < 8; k++) begin
         if (rst_i) begin
            cnt[k] <= 8'h00;
         end else if (hit[k]) begin
            cnt[k] <= cnt[k] + 8'h01;
         end
      end
   end
endmodule

// ---- dv/tb.sv ----
// testbench: register views, event notifications and pin controls
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
 num_errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   import uvee_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic pull_ctl = 1'b0;
   logic psw_on = 1'b0;
   logic [3:0] sel = 4'hf;
   logic [11:0] adr = 12'h000;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack, alt, pull, pout, poe, ser, rvb, aca, wdto;
   uvee_sense_t sense = '0;
   uvee_event_t ev;
   logic [7:0] q;
   logic [7:0] exp_cnt [8];
   int num_errors = 0;
   int total_checks = 0;
   uvee_regs #(.RESUME_WD_CYCLES(10)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
      .sense_i(sense), .id_pull_up_control_i(pull_ctl),
      .power_switch_on_i(psw_on), .event_o(ev), .alt_int_o(alt),
      .id_pull_up_o(pull), .psw_out_o(pout), .psw_oe_o(poe),
      .vbus_series_resistor_present_o(ser),
      .a_device_vbus_resistor_enable_o(rvb),
      .accessory_detect_enable_o(aca), .resume_watchdog_timeout_o(wdto));
   uvee_link_model u_link (.clk_i(clk_i), .rst_i(rst_i), .event_i(ev),
      .alt_int_i(alt), .timeout_i(wdto));
   // free-running 100 MHz clock
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   task automatic results;
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // one classic cycle; the wait is bounded so a dead slave cannot hang us
   task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {2'b00, a};
      wdat <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         num_errors++;
         results();
      end
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      `CHK(q, e)
   endtask
   // let synchronisers settle, then compare every notification count
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      for (int k = 0; k < 8; k++) `CHK(u_link.cnt[k], exp_cnt[k])
   endtask
   // hang guard far beyond the length of the whole run
   initial begin
      #400000;
      num_errors++;
      results();
   end
   initial begin
      for (int k = 0; k < 8; k++) exp_cnt[k] = 8'h00;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(UVEE_EVT_EN_ADR, 8'h40);
      rd(UVEE_CFG_SET_ADR, 8'h70);
      wb(1'b1, UVEE_CFG_CLR_ADR, 8'hff);
      rd(UVEE_CFG_SET_ADR, 8'h00);
      sense.cmp_dplus <= 1'b1;
      wb(1'b1, UVEE_CFG_SET_ADR, 8'h17);
      rd(UVEE_CFG_CLR_ADR, 8'h16);
      `CHK({ser, rvb, aca, pout, poe}, 5'b10001)
      wb(1'b1, UVEE_CFG_CLR_ADR, 8'h04);
      psw_on <= 1'b1;
      settle(3);
      `CHK({pout, poe}, 2'b11)
      wb(1'b1, UVEE_CFG_SET_ADR, 8'h08);
      settle(3);
      `CHK(pout, 1'b0)
      $display("test config views done");
      wb(1'b1, 10'h3fc, 8'hff);
      rd(10'h3fc, 8'h00);
      wb(1'b1, UVEE_EVT_EN_ADR, 8'hff);
      rd(UVEE_EVT_EN_ADR, 8'h7f);
      // a write without byte lane 0 must leave the byte alone
      sel <= 4'he;
      wb(1'b1, UVEE_EVT_EN_ADR, 8'h00);
      sel <= 4'hf;
      rd(UVEE_EVT_EN_ADR, 8'h7f);
      settle(2);
      `CHK(pull, 1'b1)
      sense.vbus_mon <= 1'b1;
      exp_cnt[2]++;
      settle(8);
      sense.vbus_mon <= 1'b0;
      exp_cnt[1]++;
      settle(8);
      sense.supply_mon <= 1'b1;
      exp_cnt[0]++;
      settle(8);
      sense.supply_mon <= 1'b0;
      exp_cnt[0]++;
      settle(8);
      sense.id_open <= 1'b1;
      exp_cnt[5]++;
      settle(8);
      sense.acc_res <= 2'b10;
      exp_cnt[4]++;
      exp_cnt[6]++;
      settle(8);
      rd(UVEE_STATUS_ADR, 8'h02);
      sense.sess_wd_timeout <= 1'b1;
      exp_cnt[3]++;
      settle(8);
      sense.sess_wd_timeout <= 1'b0;
      sense.resume_k <= 1'b1;
      exp_cnt[7]++;
      settle(20);
      sense.resume_k <= 1'b0;
      $display("test enabled events done");
      wb(1'b1, UVEE_EVT_EN_ADR, 8'h00);
      settle(2);
      `CHK(pull, 1'b0)
      sense.vbus_mon <= 1'b1;
      sense.supply_mon <= 1'b1;
      sense.id_open <= 1'b0;
      sense.acc_res <= 2'b01;
      sense.sess_wd_timeout <= 1'b1;
      sense.resume_k <= 1'b1;
      settle(20);
      sense.vbus_mon <= 1'b0;
      pull_ctl <= 1'b1;
      settle(8);
      `CHK(pull, 1'b1)
      $display("test disabled events done");
      results();
   end
endmodule
